// ==== rtl/interface_monitor.sv ====
// interface monitor: error log, isolation control and traffic status
//
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/100ps

module interface_monitor #(
  parameter int CNT_W = 8  // outstanding counter width
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // erroring transaction capture
  input  wire logic        err_valid,
  input  wire logic [63:0] err_addr,
  input  wire logic [23:0] originating_txn_id,
  input  wire logic [7:0]  source_node_id,
  input  wire logic        err_write,
  input  wire logic [2:0]  err_prot,
  input  wire logic [3:0]  err_cache,
  input  wire logic        err_lock,
  input  wire logic [1:0]  err_burst,
  input  wire logic [2:0]  err_size,
  input  wire logic [7:0]  err_len,
  // traffic events at the ingress
  input  wire logic        wr_start,
  input  wire logic        wr_done,
  input  wire logic        rd_start,
  input  wire logic        rd_done,
  // isolation status
  output logic             isolated
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
    $error("CNT_W must lie between 1 and 16");
  end

  // ---------------------------------------------------------------
  // error log storage
  // ---------------------------------------------------------------
  logic [31:0] error_address_low;             // address bits 31:0
  logic [31:0] error_address_high;            // address bits 63:32
  logic [31:0] error_source_ids;              // txn id and node id
  logic [31:0] error_transaction_attributes;  // direction and attributes

  // attribute word assembled from the inputs, reserved bits zero
  wire  [31:0] attr_word;
  wire  [31:0] ids_word;

  assign ids_word = {originating_txn_id, source_node_id};

  assign attr_word = {7'h00, err_write, 2'h0, err_prot, err_cache,
                      err_lock, err_burst, 1'b0, err_size, err_len};

  // all four words load on one strobe so the log never mixes events
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      error_address_low            <= monitor_pkg::WORD_ZERO;
      error_address_high           <= monitor_pkg::WORD_ZERO;
      error_source_ids             <= monitor_pkg::WORD_ZERO;
      error_transaction_attributes <= monitor_pkg::WORD_ZERO;
    end else if (err_valid) begin
      error_address_low            <= err_addr[31:0];
      error_address_high           <= err_addr[63:32];
      error_source_ids             <= ids_word;
      error_transaction_attributes <= attr_word;
    end
  end

  // ---------------------------------------------------------------
  // outstanding transaction counters
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] wr_count;       // writes in flight
  logic [CNT_W-1:0] rd_count;       // reads in flight
  logic [CNT_W-1:0] next_wr_count;
  logic [CNT_W-1:0] next_rd_count;
  wire              wr_inc;
  wire              wr_dec;
  wire              rd_inc;
  wire              rd_dec;

  // saturate rather than wrap: a wrapped count would show idle wrongly
  assign wr_inc = wr_start && !wr_done && (wr_count != '1);
  assign wr_dec = wr_done && !wr_start && (wr_count != '0);
  assign rd_inc = rd_start && !rd_done && (rd_count != '1);
  assign rd_dec = rd_done && !rd_start && (rd_count != '0);

  assign next_wr_count = wr_inc ? wr_count + CNT_W'(1) :
                         wr_dec ? wr_count - CNT_W'(1) : wr_count;
  assign next_rd_count = rd_inc ? rd_count + CNT_W'(1) :
                         rd_dec ? rd_count - CNT_W'(1) : rd_count;

  // counters follow start and done pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_count <= '0;
      rd_count <= '0;
    end else begin
      wr_count <= next_wr_count;
      rd_count <= next_rd_count;
    end
  end

  // status levels, registered with the counters
  logic active_write;  // at least one write open
  logic active_read;   // at least one read open

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      active_write <= 1'b0;
      active_read  <= 1'b0;
    end else begin
      active_write <= (next_wr_count != '0);
      active_read  <= (next_rd_count != '0);
    end
  end

  // ---------------------------------------------------------------
  // register write decode
  // ---------------------------------------------------------------
  wire ctrl_wr;     // write to isolation control
  wire ctrl_one;    // request bit written as one
  wire ctrl_zero;   // request bit written as zero

  // writes to log and status words are dropped on purpose
  assign ctrl_wr   = reg_wr && (reg_addr == monitor_pkg::ADDR_ISO_CTRL);
  assign ctrl_one  = ctrl_wr && reg_wdata[monitor_pkg::ISO_REQ_BIT];
  assign ctrl_zero = ctrl_wr && !reg_wdata[monitor_pkg::ISO_REQ_BIT];

  // ---------------------------------------------------------------
  // isolation state machine
  // ---------------------------------------------------------------
  monitor_pkg::iso_state_t iso_state;
  monitor_pkg::iso_state_t next_iso_state;
  logic                    iso_req;  // last value of request bit
  wire                     drained;

  assign drained = (wr_count == '0) && (rd_count == '0);

  // entry waits for traffic to drain; exit takes one cycle
  always_comb begin
    next_iso_state = iso_state;
    case (iso_state)
      monitor_pkg::ISO_IDLE: begin
        if (ctrl_one) next_iso_state = monitor_pkg::ISO_PEND_ENTRY;
      end
      monitor_pkg::ISO_PEND_ENTRY: begin
        if (ctrl_zero) next_iso_state = monitor_pkg::ISO_PEND_EXIT;
        else if (drained) next_iso_state = monitor_pkg::ISO_ACTIVE;
      end
      monitor_pkg::ISO_ACTIVE: begin
        if (ctrl_zero) next_iso_state = monitor_pkg::ISO_PEND_EXIT;
      end
      monitor_pkg::ISO_PEND_EXIT: begin
        if (ctrl_one) next_iso_state = monitor_pkg::ISO_PEND_ENTRY;
        else next_iso_state = monitor_pkg::ISO_IDLE;
      end
      default: begin
        next_iso_state = monitor_pkg::ISO_IDLE;
      end
    endcase
  end

  // state, request bit and isolated output
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      iso_state <= monitor_pkg::ISO_IDLE;
      iso_req   <= 1'b0;
      isolated  <= 1'b0;
    end else begin
      iso_state <= next_iso_state;
      isolated  <= (next_iso_state == monitor_pkg::ISO_ACTIVE);
      if (ctrl_wr) iso_req <= reg_wdata[monitor_pkg::ISO_REQ_BIT];
    end
  end

  // ---------------------------------------------------------------
  // late traffic flags
  // ---------------------------------------------------------------
  logic write_received;  // write seen while isolated
  logic read_received;   // read seen while isolated
  wire  flag_clear;
  wire  in_iso;

  assign in_iso = (iso_state == monitor_pkg::ISO_ACTIVE);

  // clear only from pending entry, active or pending exit
  assign flag_clear = ctrl_one && (iso_state != monitor_pkg::ISO_IDLE);

  // a new arrival in the clearing cycle keeps its flag set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_received <= 1'b0;
      read_received  <= 1'b0;
    end else begin
      if (in_iso && wr_start) write_received <= 1'b1;
      else if (flag_clear) write_received <= 1'b0;
      if (in_iso && rd_start) read_received <= 1'b1;
      else if (flag_clear) read_received <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  wire [31:0] traffic_word;
  wire [31:0] ctrl_word;
  wire [31:0] read_word;

  // reserved status bits read zero; writes to them are ignored
  assign traffic_word = {20'h00000, write_received, read_received,
                         active_write, active_read, 8'h00};
  assign ctrl_word    = {29'h0000_0000, iso_state, iso_req};

  assign read_word =
    (reg_addr == monitor_pkg::ADDR_ERR_LOW)  ? error_address_low :
    (reg_addr == monitor_pkg::ADDR_ERR_HIGH) ? error_address_high :
    (reg_addr == monitor_pkg::ADDR_SRC_IDS)  ? error_source_ids :
    (reg_addr == monitor_pkg::ADDR_ATTRS)    ? error_transaction_attributes :
    (reg_addr == monitor_pkg::ADDR_TRAFFIC)  ? traffic_word :
    (reg_addr == monitor_pkg::ADDR_ISO_CTRL) ? ctrl_word :
                                               monitor_pkg::WORD_ZERO;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reg_rdata <= monitor_pkg::WORD_ZERO;
    else if (reg_rd) reg_rdata <= read_word;
    else reg_rdata <= monitor_pkg::WORD_ZERO;
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // capture strobe and the cycle in which the log shows it
  sequence s_err_logged;
    err_valid ##1 1'b1;
  endsequence

  // first write opening from an idle write count
  sequence s_wr_first;
    wr_start && !wr_done && (wr_count == '0);
  endsequence

  // last write closing, count about to reach zero
  sequence s_wr_last;
    wr_done && !wr_start && (wr_count == CNT_W'(1));
  endsequence

  // first read opening from an idle read count
  sequence s_rd_first;
    rd_start && !rd_done && (rd_count == '0);
  endsequence

  // last read closing, count about to reach zero
  sequence s_rd_last;
    rd_done && !rd_start && (rd_count == CNT_W'(1));
  endsequence

  // ---------------------------------------------------------------
  // log capture checks
  // ---------------------------------------------------------------
  a_addr_low_log: assert property (err_valid |=> error_address_low == $past(err_addr[31:0]))
    else $error("low address word not logged");
  a_addr_high_log: assert property (err_valid |=> error_address_high == $past(err_addr[63:32]))
    else $error("high address word not logged");
  a_txn_id_log: assert property (s_err_logged |-> error_source_ids[31:8] == $past(originating_txn_id))
    else $error("txn id not logged");
  a_node_id_log: assert property (err_valid |=> error_source_ids[7:0] == $past(source_node_id))
    else $error("node id not logged");
  a_dir_bit: assert property (err_valid |=> error_transaction_attributes[24] == $past(err_write))
    else $error("direction bit wrong");
  a_prot_cache: assert property (err_valid |=>
      error_transaction_attributes[21:15] == {$past(err_prot), $past(err_cache)})
    else $error("prot or cache wrong");
  a_cache_field: assert property (err_valid |=> error_transaction_attributes[18:15] == $past(err_cache))
    else $error("cache field wrong");
  a_lock_burst: assert property (err_valid |=>
      error_transaction_attributes[14:12] == {$past(err_lock), $past(err_burst)})
    else $error("lock or burst wrong");
  a_burst_field: assert property (err_valid |=> error_transaction_attributes[13:12] == $past(err_burst))
    else $error("burst field wrong");
  a_size_len: assert property (err_valid |=>
      error_transaction_attributes[10:0] == {$past(err_size), $past(err_len)})
    else $error("size or len wrong");
  a_len_field: assert property (err_valid |=> error_transaction_attributes[7:0] == $past(err_len))
    else $error("len field wrong");

  // ---------------------------------------------------------------
  // late flag checks
  // ---------------------------------------------------------------
  a_late_write: assert property (in_iso && wr_start |=> write_received)
    else $error("late write not flagged");
  a_clear_write: assert property (flag_clear && !(in_iso && wr_start) |=> !write_received)
    else $error("late write flag not cleared");
  a_late_read: assert property (in_iso && rd_start |=> read_received)
    else $error("late read not flagged");
  a_clear_read: assert property (flag_clear && !(in_iso && rd_start) |=> !read_received)
    else $error("late read flag not cleared");
  // flags only rise on a start while isolated, never by themselves
  a_write_no_rise: assert property (!write_received && !(in_iso && wr_start) |=> !write_received)
    else $error("late write flag rose without cause");
  a_read_no_rise: assert property (!read_received && !(in_iso && rd_start) |=> !read_received)
    else $error("late read flag rose without cause");
  // once set, a flag waits for the clearing write
  a_write_flag_hold: assert property (write_received && !flag_clear |=> write_received)
    else $error("late write flag dropped early");
  a_read_flag_hold: assert property (read_received && !flag_clear |=> read_received)
    else $error("late read flag dropped early");

  // ---------------------------------------------------------------
  // outstanding traffic checks
  // ---------------------------------------------------------------
  a_active_write: assert property (##1 active_write == (wr_count != '0))
    else $error("active write disagrees with count");
  a_active_read: assert property (##1 active_read == (rd_count != '0))
    else $error("active read disagrees with count");
  // the edges of the status bits, checked against the pulses themselves
  a_write_opens: assert property (s_wr_first |=> active_write)
    else $error("first write not shown");
  a_write_closes: assert property (s_wr_last |=> !active_write)
    else $error("last write not cleared");
  a_read_opens: assert property (s_rd_first |=> active_read)
    else $error("first read not shown");
  a_read_closes: assert property (s_rd_last |=> !active_read)
    else $error("last read not cleared");

  // ---------------------------------------------------------------
  // log consistency and read-only checks
  // ---------------------------------------------------------------
  a_log_hold: assert property (!err_valid |=> $stable(error_source_ids) && $stable(error_address_low))
    else $error("log changed without an event");
  a_log_hold_rest: assert property (!err_valid |=>
      $stable(error_address_high) && $stable(error_transaction_attributes))
    else $error("log changed without an event");
  a_ro_reserved: assert property (reg_rd && reg_addr == monitor_pkg::ADDR_ATTRS |=>
      reg_rdata[31:25] == 7'h00 && reg_rdata[11] == 1'b0)
    else $error("reserved bits not zero");
  // status reserved bits read zero whatever software wrote there
  a_status_reserved: assert property (reg_rd && reg_addr == monitor_pkg::ADDR_TRAFFIC |=>
      reg_rdata[31:12] == 20'h00000 && reg_rdata[7:0] == 8'h00)
    else $error("status reserved bits not zero");
  // read data stand only in the cycle after a strobe
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == monitor_pkg::WORD_ZERO)
    else $error("read data outside its cycle");
  // isolated output follows the active state exactly
  a_iso_output: assert property (isolated == in_iso)
    else $error("isolated output disagrees with state");

endmodule : interface_monitor

// ==== rtl/monitor_pkg.sv ====
// constants shared by the interface monitor error and isolation log
package monitor_pkg;

  // ---------------------------------------------------------------
  // register word addresses (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_ERR_LOW   = 8'h00;  // error_address_low
  localparam logic [7:0] ADDR_ERR_HIGH  = 8'h04;  // error_address_high
  localparam logic [7:0] ADDR_SRC_IDS   = 8'h08;  // error_source_ids
  localparam logic [7:0] ADDR_ATTRS     = 8'h0c;  // error_transaction_attributes
  localparam logic [7:0] ADDR_TRAFFIC   = 8'h10;  // isolation_traffic_status
  localparam logic [7:0] ADDR_ISO_CTRL  = 8'h14;  // isolation_control_reg

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int NODE_LSB   = 0;   // source node id, 8 bits
  localparam int TXN_LSB    = 8;   // originating txn id, 24 bits
  localparam int LEN_LSB    = 0;   // burst length, 8 bits
  localparam int SIZE_LSB   = 8;   // beat size, 3 bits
  localparam int BURST_LSB  = 12;  // burst type, 2 bits
  localparam int LOCK_BIT   = 14;  // lock
  localparam int CACHE_LSB  = 15;  // cache, 4 bits
  localparam int PROT_LSB   = 19;  // protection, 3 bits
  localparam int DIR_BIT    = 24;  // 1 write, 0 read
  localparam int ACT_RD_BIT = 8;   // read outstanding
  localparam int ACT_WR_BIT = 9;   // write outstanding
  localparam int LATE_RD_BIT = 10; // read after isolation
  localparam int LATE_WR_BIT = 11; // write after isolation
  localparam int ISO_REQ_BIT = 0;  // isolation request
  localparam int ISO_ST_LSB  = 1;  // isolation state, 2 bits

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // ---------------------------------------------------------------
  // isolation state machine
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ISO_IDLE       = 2'b00,  // traffic flows
    ISO_PEND_ENTRY = 2'b01,  // draining before isolation
    ISO_ACTIVE     = 2'b10,  // isolated
    ISO_PEND_EXIT  = 2'b11   // leaving isolation
  } iso_state_t;

endpackage : monitor_pkg

// ==== testbench/tb_interface_monitor.sv ====
// self-checking testbench of the interface monitor error log and traffic status
`timescale 1ns/100ps

module tb_interface_monitor;
  // ---------------------------------------------------------------
  // stimulus rows: one erroring transaction and the words it should log
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [63:0] a;       // erroring address
    logic [23:0] id;      // originating txn id
    logic [7:0]  nd;      // source node id
    logic        w;       // 1 write, 0 read
    logic [2:0]  pr;      // protection
    logic [3:0]  ca;      // cache
    logic        lk;      // lock
    logic [1:0]  bu;      // burst type
    logic [2:0]  sz;      // beat size
    logic [7:0]  ln;      // burst length
    logic [31:0] e_ids;   // expected id word
    logic [31:0] e_attr;  // expected attribute word
  } row_t;
  // mixed fields, all ones (reserved bits must stay zero), a read
  localparam row_t ROWS [3] = '{
    '{64'h89ab_cdef_0123_4567, 24'hfedcba, 8'h5a, 1'b1, 3'h5, 4'ha, 1'b1, 2'h2, 3'h6, 8'hc3, 32'hfedc_ba5a, 32'h012d_66c3},
    '{64'hffff_ffff_ffff_ffff, 24'hffffff, 8'hff, 1'b1, 3'h7, 4'hf, 1'b1, 2'h3, 3'h7, 8'hff, 32'hffff_ffff, 32'h013f_f7ff},
    '{64'h0000_0001_8000_0000, 24'h000001, 8'h00, 1'b0, 3'h2, 4'h5, 1'b0, 2'h1, 3'h2, 8'h00, 32'h0000_0100, 32'h0012_9200}};

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk;          // 200 MHz clock
  logic        rstn;         // async reset, active low
  logic [7:0]  reg_addr;     // register address
  logic [31:0] reg_wdata;    // write data
  logic        reg_wr;       // write strobe
  logic        reg_rd;       // read strobe
  logic [31:0] reg_rdata;    // read data
  logic        err_valid;    // capture strobe
  logic [63:0] err_addr;     // capture address
  logic [23:0] txn_id;       // capture txn id
  logic [7:0]  node_id;      // capture node id
  logic        err_write;    // capture direction
  logic [2:0]  err_prot;     // capture protection
  logic [3:0]  err_cache;    // capture cache
  logic        err_lock;     // capture lock
  logic [1:0]  err_burst;    // capture burst
  logic [2:0]  err_size;     // capture size
  logic [7:0]  err_len;      // capture length
  logic [3:0]  evt;          // wr_start, wr_done, rd_start, rd_done
  logic        isolated;     // isolation active
  logic [31:0] rd;           // last read word
  int          n_errors;     // mismatches
  int          comparisons;  // compares made

  interface_monitor uut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .err_valid(err_valid), .err_addr(err_addr), .originating_txn_id(txn_id),
    .source_node_id(node_id), .err_write(err_write), .err_prot(err_prot), .err_cache(err_cache),
    .err_lock(err_lock), .err_burst(err_burst), .err_size(err_size), .err_len(err_len),
    .wr_start(evt[0]), .wr_done(evt[1]), .rd_start(evt[2]), .rd_done(evt[3]), .isolated(isolated));

  // clock: invert every half period
  always #2.5 clk = ~clk;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  // compare and count; case inequality so unknowns never match
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // one-cycle write; strobe dropped on the edge that takes it
  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask : reg_write

  // one-cycle read; data stand only in the following cycle
  task automatic reg_read(input logic [7:0] a);
    @(posedge clk) begin reg_rd <= 1'b1; reg_addr <= a; end
    @(posedge clk) reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_read

  // read a word and compare it
  task automatic expect_word(input logic [7:0] a, input logic [31:0] exp);
    reg_read(a);
    check(rd, exp);
  endtask : expect_word

  // one-cycle pulse on the traffic event lines
  task automatic pulse(input logic [3:0] v);
    @(posedge clk) evt <= v;
    @(posedge clk) evt <= 4'h0;
  endtask : pulse

  // verdict and end of run
  task automatic conclude();
    if (n_errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  // watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    conclude();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0; rstn = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0; reg_rd = 1'b0;
    err_valid = 1'b0; err_addr = 64'h0; txn_id = 24'h0; node_id = 8'h0; err_write = 1'b0;
    err_prot = 3'h0; err_cache = 4'h0; err_lock = 1'b0; err_burst = 2'h0; err_size = 3'h0; err_len = 8'h0;
    evt = 4'h0; n_errors = 0; comparisons = 0; rd = 32'h0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    // reset values of every word, plus unmapped places reading zero
    for (int i = 0; i < 8; i++) expect_word(8'(i * 4), 32'h0);
    check({31'h0, isolated}, 32'h0);
    // capture rows: each event lands whole in all four log words
    foreach (ROWS[i]) begin
      @(posedge clk) begin
        err_valid <= 1'b1; err_addr <= ROWS[i].a; txn_id <= ROWS[i].id; node_id <= ROWS[i].nd;
        err_write <= ROWS[i].w; err_prot <= ROWS[i].pr; err_cache <= ROWS[i].ca; err_lock <= ROWS[i].lk;
        err_burst <= ROWS[i].bu; err_size <= ROWS[i].sz; err_len <= ROWS[i].ln;
      end
      @(posedge clk) err_valid <= 1'b0;
      expect_word(monitor_pkg::ADDR_ERR_LOW, ROWS[i].a[31:0]);
      expect_word(monitor_pkg::ADDR_ERR_HIGH, ROWS[i].a[63:32]);
      expect_word(monitor_pkg::ADDR_SRC_IDS, ROWS[i].e_ids);
      expect_word(monitor_pkg::ADDR_ATTRS, ROWS[i].e_attr);
    end
    // log words ignore software writes; status flag bits written as ones read back zero
    for (int i = 0; i < 4; i++) reg_write(8'(i * 4), 32'ha5a5_5a5a);
    reg_write(monitor_pkg::ADDR_TRAFFIC, 32'h0000_0f00);
    expect_word(monitor_pkg::ADDR_ERR_LOW, ROWS[2].a[31:0]);
    expect_word(monitor_pkg::ADDR_ATTRS, ROWS[2].e_attr);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0);
    // outstanding traffic bits follow the counts
    pulse(4'b0001);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0000_0200);
    pulse(4'b0100);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0000_0300);
    pulse(4'b0010);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0000_0100);
    // isolation request waits for the read to drain
    reg_write(monitor_pkg::ADDR_ISO_CTRL, 32'h1);
    expect_word(monitor_pkg::ADDR_ISO_CTRL, 32'h3);
    check({31'h0, isolated}, 32'h0);
    pulse(4'b1000);
    repeat (2) @(posedge clk);
    expect_word(monitor_pkg::ADDR_ISO_CTRL, 32'h5);
    check({31'h0, isolated}, 32'h1);
    // starts during isolation raise the late flags, one direction at a time
    pulse(4'b0001);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0000_0a00);
    pulse(4'b0100);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0000_0f00);
    // write one again while active clears both flags, counts untouched
    reg_write(monitor_pkg::ADDR_ISO_CTRL, 32'h1);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0000_0300);
    pulse(4'b1010);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0);
    // leave isolation; a start in idle sets no late flag
    reg_write(monitor_pkg::ADDR_ISO_CTRL, 32'h0);
    repeat (2) @(posedge clk);
    expect_word(monitor_pkg::ADDR_ISO_CTRL, 32'h0);
    check({31'h0, isolated}, 32'h0);
    pulse(4'b0100);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0000_0100);
    // mid-run reset returns the log and status to zero
    @(posedge clk) rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    expect_word(monitor_pkg::ADDR_ERR_HIGH, 32'h0);
    expect_word(monitor_pkg::ADDR_TRAFFIC, 32'h0);
    conclude();
  end
endmodule : tb_interface_monitor
